// File: include/gss_pkg.sv
// shared constants and types for the generator start/stop and alarm input block
package gss_pkg;

    // register byte offsets on the plain register port
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_IN_CFG = 8'h04;
    localparam logic [7:0] ADR_IN_STATE = 8'h08;
    localparam logic [7:0] ADR_MIN_RUN = 8'h0C;
    localparam logic [7:0] ADR_WARM = 8'h10;
    localparam logic [7:0] ADR_COOL = 8'h14;
    localparam logic [7:0] ADR_SVC_INT = 8'h18;
    localparam logic [7:0] ADR_GEN_STATE = 8'h1C;
    localparam logic [7:0] ADR_RUN_TIME = 8'h20;
    localparam logic [7:0] ADR_TOTAL = 8'h24;
    localparam logic [7:0] ADR_SVC_LEFT = 8'h28;
    localparam logic [7:0] ADR_HIST = 8'h30;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h4C;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h50;

    // control register bit positions
    localparam int CTL_AUTO_EN = 0;
    localparam int CTL_MANUAL = 1;
    localparam int CTL_DETECT = 2;
    localparam int CTL_NOAUTO_ALM = 3;
    localparam int CTL_COND_REQ = 4;
    localparam int CTL_RST_SVC = 5;
    localparam int CTL_RST_DAILY = 6;
    localparam int CTL_W = 5;

    // per-input configuration byte layout
    localparam int CFG_STRIDE = 8;
    localparam int CFG_FUNC_LSB = 0;
    localparam int CFG_FUNC_W = 4;
    localparam int CFG_ALARM_EN = 4;
    localparam int CFG_LABEL_INV = 5;
    localparam int CFG_LOGIC_INV = 6;

    // input state register field positions
    localparam int ST_ACT_LSB = 0;
    localparam int ST_LABEL_LSB = 8;
    localparam int ST_ALARM_LSB = 16;

    // input function codes
    localparam logic [3:0] FN_DISABLED = 4'h0;
    localparam logic [3:0] FN_PULSE = 4'h1;
    localparam logic [3:0] FN_DOOR = 4'h2;
    localparam logic [3:0] FN_BILGE_PUMP = 4'h3;
    localparam logic [3:0] FN_BILGE = 4'h4;
    localparam logic [3:0] FN_BURGLAR = 4'h5;
    localparam logic [3:0] FN_SMOKE = 4'h6;
    localparam logic [3:0] FN_FIRE = 4'h7;
    localparam logic [3:0] FN_CO2 = 4'h8;
    localparam logic [3:0] FN_GENERATOR = 4'h9;

    // interrupt status bits
    localparam int IRQ_INPUT = 0;
    localparam int IRQ_NO_AC = 1;
    localparam int IRQ_NOAUTO = 2;
    localparam int IRQ_SERVICE = 3;
    localparam int IRQ_W = 4;

    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int NOAUTO_LIMIT_MIN = 10;
    localparam int NOAUTO_LIMIT_S = NOAUTO_LIMIT_MIN * 60;
    localparam int STOP_HOLD_S = 15;
    localparam int DAY_S = 86400;
    localparam int HIST_DAYS = 7;

    // reset values of the setting registers, in seconds
    localparam logic [31:0] MIN_RUN_RST = 32'h0000_0000;
    localparam logic [31:0] WARM_RST = 32'h0000_003C;
    localparam logic [31:0] COOL_RST = 32'h0000_00B4;
    localparam logic [31:0] SVC_INT_RST = 32'h0000_0000;

    // generator controller states
    typedef enum logic [2:0] {
        GEN_STOPPED,
        GEN_WARMUP,
        GEN_MANUAL,
        GEN_COND_RUN,
        GEN_COOLDOWN,
        GEN_STOPPING
    } gss_gen_state_type;

endpackage

// File: logic/gss_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module gss_sync
    import gss_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // first stage, read only by the second stage
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // next values: plain shift
    always_comb
    begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // register both stages
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end

endmodule

// File: logic/gss_core.sv
// digital alarm inputs and generator start/stop controller with register port
`timescale 1ns/1ns

module gss_core
    import gss_pkg::*;
#(
    parameter int N_IN = 4,
    parameter int SEC_CYC = CLK_HZ,
    parameter int DAY_SEC = DAY_S
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [N_IN-1:0] din_pin,
    input wire logic ac_present_pin,
    output logic relay1,
    output logic relay2,
    output logic ac_connect,
    output logic irq
);

    // elaboration check on parameters
    if (N_IN < 1 || N_IN > 4 || SEC_CYC < 2 || DAY_SEC < 2)
    begin : g_bad_param
        $error("gss_core: unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation and evaluation

    logic [N_IN:0] sync_q; // synchronised pins, ac presence on top
    logic [N_IN-1:0] in_act; // active condition per input
    logic [N_IN-1:0] in_label; // label code per input
    logic [N_IN-1:0] in_alarm; // reported alarm per input
    logic [31:0] cfg_r; // per-input configuration bytes
    logic ac_ok; // ac seen at inverter input

    gss_sync #(.W(N_IN + 1)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({ac_present_pin, din_pin}),
        .q(sync_q)
    );
    assign ac_ok = sync_q[N_IN];

    for (genvar i = 0; i < N_IN; i++)
    begin : g_in
        logic [3:0] fn; // function code of this input
        logic lvl_act; // level after logic inversion
        logic labelled; // function reports two labels
        assign fn = cfg_r[i*CFG_STRIDE+CFG_FUNC_LSB +: CFG_FUNC_W];
        assign lvl_act = sync_q[i] ^ cfg_r[i*CFG_STRIDE+CFG_LOGIC_INV];
        // pulse meter and unused codes have no labels
        assign labelled = (fn >= FN_DOOR) && (fn <= FN_GENERATOR);
        assign in_act[i] = labelled & lvl_act;
        assign in_label[i] = labelled & (lvl_act ^ cfg_r[i*CFG_STRIDE+CFG_LABEL_INV]);
        assign in_alarm[i] = in_act[i] & cfg_r[i*CFG_STRIDE+CFG_ALARM_EN];
    end

    ////////////////////////////////////////////////////////////////////////////
    // register and controller state

    logic [CTL_W-1:0] ctrl_r, ctrl_nxt; // stored control bits
    logic [31:0] cfg_nxt;
    logic [31:0] min_run_r, min_run_nxt; // minimum run, seconds
    logic [31:0] warm_r, warm_nxt; // warm-up time, seconds
    logic [31:0] cool_r, cool_nxt; // cool-down time, seconds
    logic [31:0] svc_int_r, svc_int_nxt; // service interval, seconds
    logic [31:0] run_r, run_nxt; // run time since last start
    logic [31:0] total_r, total_nxt; // accumulated run time
    logic [31:0] svc_left_r, svc_left_nxt; // time to next service
    logic [31:0] phase_r, phase_nxt; // seconds in timed state
    logic [31:0] sec_cnt_r, sec_cnt_nxt; // one-second prescaler
    logic [31:0] day_cnt_r, day_cnt_nxt; // seconds into current day
    logic [31:0] noauto_r, noauto_nxt; // seconds with auto disabled
    logic [31:0] hist_r [HIST_DAYS]; // daily run seconds
    logic [31:0] hist_nxt [HIST_DAYS];
    logic [2:0] day_ptr_r, day_ptr_nxt; // history slot of today
    gss_gen_state_type state_r, state_nxt;
    logic auto_start_r, auto_start_nxt; // current run began automatically
    logic [N_IN-1:0] alarm_prev_r; // for input alarm edges
    logic noac_prev_r, noauto_prev_r; // for alarm edges
    logic [IRQ_W-1:0] stat_r, stat_nxt; // sticky event status
    logic [IRQ_W-1:0] mask_r, mask_nxt; // interrupt mask
    logic [31:0] rdata_nxt;
    logic relay1_nxt, ac_connect_nxt, irq_nxt;

    // decoded helpers
    logic sec_tick; // one pulse per second
    logic running; // relay closed
    logic req_manual, req_auto; // start requests
    logic noac_alm, noauto_alm; // alarm levels
    logic [IRQ_W-1:0] events;
    logic wr_ctrl;

    assign sec_tick = (sec_cnt_r == 32'(SEC_CYC - 1));
    // relay closed through warm-up, run and cool-down
    assign running = (state_r == GEN_WARMUP) || (state_r == GEN_MANUAL)
        || (state_r == GEN_COND_RUN) || (state_r == GEN_COOLDOWN);
    assign req_manual = ctrl_r[CTL_MANUAL];
    // conditions count only with auto enabled
    assign req_auto = ctrl_r[CTL_AUTO_EN] & ctrl_r[CTL_COND_REQ];
    assign noac_alm = ctrl_r[CTL_DETECT] & ~ac_ok
        & ((state_r == GEN_MANUAL) || (state_r == GEN_COND_RUN));
    // auto disabled for more than the limit
    assign noauto_alm = ctrl_r[CTL_NOAUTO_ALM] & (noauto_r > 32'(NOAUTO_LIMIT_S));
    assign wr_ctrl = reg_wr && (reg_addr == ADR_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // generator state machine and timers

    always_comb
    begin
        state_nxt = state_r;
        auto_start_nxt = auto_start_r;
        phase_nxt = (sec_tick) ? phase_r + 32'h1 : phase_r;
        run_nxt = (sec_tick && running) ? run_r + 32'h1 : run_r;
        case (state_r)
            // waiting for a start request
            GEN_STOPPED:
            begin
                if (req_manual || req_auto)
                begin
                    state_nxt = GEN_WARMUP;
                    auto_start_nxt = ~req_manual;
                    phase_nxt = 32'h0;
                    // run time restarts on each start
                    run_nxt = 32'h0;
                end
            end
            // warm up before load is connected
            GEN_WARMUP:
            begin
                if (phase_r >= warm_r)
                begin
                    state_nxt = (req_manual) ? GEN_MANUAL : GEN_COND_RUN;
                end
            end
            // held on by the manual request
            GEN_MANUAL:
            begin
                if (!req_manual)
                begin
                    state_nxt = (req_auto) ? GEN_COND_RUN : GEN_COOLDOWN;
                    phase_nxt = 32'h0;
                end
            end
            // held on by a condition
            GEN_COND_RUN:
            begin
                if (req_manual)
                begin
                    state_nxt = GEN_MANUAL;
                end
                // minimum run applies to automatic starts only
                else if (!req_auto && (!auto_start_r || run_r >= min_run_r))
                begin
                    state_nxt = GEN_COOLDOWN;
                    phase_nxt = 32'h0;
                end
            end
            // cool down after load is disconnected
            GEN_COOLDOWN:
            begin
                if (req_manual || req_auto)
                begin
                    state_nxt = (req_manual) ? GEN_MANUAL : GEN_COND_RUN;
                end
                else if (phase_r >= cool_r)
                begin
                    state_nxt = GEN_STOPPING;
                    phase_nxt = 32'h0;
                end
            end
            // relay open, engine given time to run down
            GEN_STOPPING:
            begin
                if (phase_r >= 32'(STOP_HOLD_S))
                begin
                    state_nxt = GEN_STOPPED;
                end
            end
            default:
            begin
                state_nxt = GEN_STOPPED;
            end
        endcase
        // only relay one follows the generator
        relay1_nxt = (state_nxt == GEN_WARMUP) || (state_nxt == GEN_MANUAL)
            || (state_nxt == GEN_COND_RUN) || (state_nxt == GEN_COOLDOWN);
        // load connected only outside warm-up and cool-down
        ac_connect_nxt = (state_nxt == GEN_MANUAL) || (state_nxt == GEN_COND_RUN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters, history and register writes

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        min_run_nxt = min_run_r;
        warm_nxt = warm_r;
        cool_nxt = cool_r;
        svc_int_nxt = svc_int_r;
        mask_nxt = mask_r;
        sec_cnt_nxt = (sec_tick) ? 32'h0 : sec_cnt_r + 32'h1;
        // total accumulates while the relay is closed
        total_nxt = (sec_tick && running) ? total_r + 32'h1 : total_r;
        // service countdown while running, stops at zero
        svc_left_nxt = svc_left_r;
        if (sec_tick && running && svc_left_r != 32'h0)
        begin
            svc_left_nxt = svc_left_r - 32'h1;
        end
        // seconds spent with auto disabled, saturating
        noauto_nxt = noauto_r;
        if (ctrl_r[CTL_AUTO_EN])
        begin
            noauto_nxt = 32'h0;
        end
        else if (sec_tick && noauto_r != 32'hFFFF_FFFF)
        begin
            noauto_nxt = noauto_r + 32'h1;
        end
        // day roll-over moves to the next slot and clears it
        day_cnt_nxt = day_cnt_r;
        day_ptr_nxt = day_ptr_r;
        for (int d = 0; d < HIST_DAYS; d++)
        begin
            hist_nxt[d] = hist_r[d];
        end
        if (sec_tick)
        begin
            if (day_cnt_r == 32'(DAY_SEC - 1))
            begin
                day_cnt_nxt = 32'h0;
                day_ptr_nxt = (day_ptr_r == 3'(HIST_DAYS - 1)) ? 3'h0 : day_ptr_r + 3'h1;
                hist_nxt[day_ptr_nxt] = 32'h0;
            end
            else
            begin
                day_cnt_nxt = day_cnt_r + 32'h1;
                if (running)
                begin
                    hist_nxt[day_ptr_r] = hist_r[day_ptr_r] + 32'h1;
                end
            end
        end
        // software writes take precedence over counting
        if (reg_wr)
        begin
            case (reg_addr)
                ADR_CTRL: ctrl_nxt = reg_wdata[CTL_W-1:0];
                ADR_IN_CFG: cfg_nxt = reg_wdata;
                ADR_MIN_RUN: min_run_nxt = reg_wdata;
                ADR_WARM: warm_nxt = reg_wdata;
                ADR_COOL: cool_nxt = reg_wdata;
                ADR_SVC_INT: svc_int_nxt = reg_wdata;
                // total run time overwritten by software
                ADR_TOTAL: total_nxt = reg_wdata;
                ADR_IRQ_MASK: mask_nxt = reg_wdata[IRQ_W-1:0];
                default: mask_nxt = mask_nxt;
            endcase
        end
        // service timer restarts from the interval
        if (wr_ctrl && reg_wdata[CTL_RST_SVC])
        begin
            svc_left_nxt = svc_int_r;
        end
        if (wr_ctrl && reg_wdata[CTL_RST_DAILY])
        begin
            for (int d = 0; d < HIST_DAYS; d++)
            begin
                hist_nxt[d] = 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and read port

    always_comb
    begin
        events = '0;
        events[IRQ_INPUT] = |(in_alarm & ~alarm_prev_r);
        events[IRQ_NO_AC] = noac_alm & ~noac_prev_r;
        events[IRQ_NOAUTO] = noauto_alm & ~noauto_prev_r;
        events[IRQ_SERVICE] = sec_tick && running && (svc_left_r == 32'h1);
        // write-one-to-clear, a new event in the same cycle wins
        stat_nxt = stat_r;
        if (reg_wr && reg_addr == ADR_IRQ_STAT)
        begin
            stat_nxt = stat_nxt & ~reg_wdata[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | events;
        irq_nxt = |(stat_nxt & mask_nxt);
        // read data only in the cycle after the strobe
        rdata_nxt = 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                ADR_CTRL: rdata_nxt = 32'(ctrl_r);
                ADR_IN_CFG: rdata_nxt = cfg_r;
                ADR_IN_STATE:
                begin
                    rdata_nxt[ST_ACT_LSB +: N_IN] = in_act;
                    rdata_nxt[ST_LABEL_LSB +: N_IN] = in_label;
                    rdata_nxt[ST_ALARM_LSB +: N_IN] = in_alarm;
                end
                ADR_MIN_RUN: rdata_nxt = min_run_r;
                ADR_WARM: rdata_nxt = warm_r;
                ADR_COOL: rdata_nxt = cool_r;
                ADR_SVC_INT: rdata_nxt = svc_int_r;
                ADR_GEN_STATE: rdata_nxt = {29'h0, state_r};
                ADR_RUN_TIME: rdata_nxt = run_r;
                ADR_TOTAL: rdata_nxt = total_r;
                ADR_SVC_LEFT: rdata_nxt = svc_left_r;
                ADR_IRQ_STAT: rdata_nxt = 32'(stat_r);
                ADR_IRQ_MASK: rdata_nxt = 32'(mask_r);
                default:
                begin
                    for (int d = 0; d < HIST_DAYS; d++)
                    begin
                        if (reg_addr == ADR_HIST + 8'(4 * d))
                        begin
                            rdata_nxt = hist_r[d];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_r <= '0;
            cfg_r <= 32'h0;
            min_run_r <= MIN_RUN_RST;
            warm_r <= WARM_RST;
            cool_r <= COOL_RST;
            svc_int_r <= SVC_INT_RST;
            run_r <= 32'h0;
            total_r <= 32'h0;
            svc_left_r <= SVC_INT_RST;
            phase_r <= 32'h0;
            sec_cnt_r <= 32'h0;
            day_cnt_r <= 32'h0;
            noauto_r <= 32'h0;
            for (int d = 0; d < HIST_DAYS; d++)
            begin
                hist_r[d] <= 32'h0;
            end
            day_ptr_r <= 3'h0;
            state_r <= GEN_STOPPED;
            auto_start_r <= 1'b0;
            alarm_prev_r <= '0;
            noac_prev_r <= 1'b0;
            noauto_prev_r <= 1'b0;
            stat_r <= '0;
            mask_r <= '0;
            reg_rdata <= 32'h0;
            relay1 <= 1'b0;
            relay2 <= 1'b0;
            ac_connect <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            min_run_r <= min_run_nxt;
            warm_r <= warm_nxt;
            cool_r <= cool_nxt;
            svc_int_r <= svc_int_nxt;
            run_r <= run_nxt;
            total_r <= total_nxt;
            svc_left_r <= svc_left_nxt;
            phase_r <= phase_nxt;
            sec_cnt_r <= sec_cnt_nxt;
            day_cnt_r <= day_cnt_nxt;
            noauto_r <= noauto_nxt;
            hist_r <= hist_nxt;
            day_ptr_r <= day_ptr_nxt;
            state_r <= state_nxt;
            auto_start_r <= auto_start_nxt;
            alarm_prev_r <= in_alarm;
            noac_prev_r <= noac_alm;
            noauto_prev_r <= noauto_alm;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            reg_rdata <= rdata_nxt;
            relay1 <= relay1_nxt;
            // second relay never used for the generator
            relay2 <= 1'b0;
            ac_connect <= ac_connect_nxt;
            irq <= irq_nxt;
        end
    end

endmodule

// File: bench/gss_gen_model.sv
// generator behind the run relay: makes ac power while its start contact is held
`timescale 1ns/1ns
module gss_gen_model
#(
    parameter int START_CYC = 5
)
(
    input wire logic clk_sys,
    input wire logic relay1,
    input wire logic no_fuel,
    output logic ac_present
);
    // cycles since the contact closed, saturating
    int run_cnt = 0;

    // engine stops the moment the contact opens, so a pulse never keeps it going
    always @(posedge clk_sys)
    begin
        if (!relay1)
            run_cnt <= 0;
        else if (run_cnt < START_CYC)
            run_cnt <= run_cnt + 1;
    end

    // no fuel: engine cranks but gives no power
    assign ac_present = (run_cnt >= START_CYC) && !no_fuel;
endmodule

// File: bench/gss_core_properties.sv
// port checks for the generator start/stop and alarm input block
`timescale 1ns/1ns
module gss_core_props
    import gss_pkg::*;
#(
    parameter int N_IN = 4,
    parameter int SEC_CYC = CLK_HZ,
    parameter int DAY_SEC = DAY_S
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [N_IN-1:0] din_pin,
    input wire logic ac_present_pin,
    input wire logic relay1,
    input wire logic relay2,
    input wire logic ac_connect,
    input wire logic irq
);
    // past the stopping hold, so a new start must be taken
    localparam logic [31:0] STOP_CYC = 32'((STOP_HOLD_S + 1) * SEC_CYC);
    logic [31:0] low_cnt_r, low_cnt_nxt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // cycles with the relay open, saturating
    always_comb
    begin
        low_cnt_nxt = low_cnt_r;
        if (relay1)
            low_cnt_nxt = 32'h0;
        else if (low_cnt_r != 32'hFFFF_FFFF)
            low_cnt_nxt = low_cnt_r + 32'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            low_cnt_r <= 32'h0;
        else
            low_cnt_r <= low_cnt_nxt;
    end
    ////////////////////////////////////////////////////////////////////////
    // second relay idle
    relay2_idle_a: assert property (!relay2)
        else $error("second relay driven");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    state_code_a: assert property (reg_rd && reg_addr == ADR_GEN_STATE |=> reg_rdata <= 32'h5)
        else $error("state code out of range");
    load_relay_a: assert property (ac_connect |-> relay1)
        else $error("load connected with relay open");
    warm_no_load_a: assert property ($rose(relay1) |-> !ac_connect)
        else $error("load connected at start");
    cool_relay_a: assert property ($fell(ac_connect) |-> relay1)
        else $error("relay dropped with load");
    relay_hold_a: assert property ($rose(relay1) |-> relay1 [*8])
        else $error("relay pulsed");
    start_relay_a: assert property (reg_wr && reg_addr == ADR_CTRL && reg_wdata[CTL_MANUAL]
        && low_cnt_r > STOP_CYC |-> ##2 relay1)
        else $error("start not answered");
    irq_mask_a: assert property (reg_wr && reg_addr == ADR_IRQ_MASK && reg_wdata[3:0] == 4'h0
        |=> !irq)
        else $error("masked interrupt seen");
    cover property ($rose(relay1));
    cover property ($fell(ac_connect));
    cover property ($rose(irq));
endmodule

// File: bench/gss_core_tb.sv
// self-checking bench for the generator start/stop and alarm input block
`timescale 1ns/1ns
module gss_core_tb
    import gss_pkg::*;
;
    localparam int SEC = 10;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] din_pin = 4'h0;
    logic no_fuel = 1'b0;
    logic [31:0] reg_rdata;
    logic ac_present_pin, relay1, relay2, ac_connect, irq;
    logic [31:0] cfg;
    int n_fail = 0, samples_checked = 0;

    initial
    forever
        #10 clk_sys = ~clk_sys;

    gss_core #(.N_IN(4), .SEC_CYC(SEC), .DAY_SEC(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .din_pin(din_pin), .ac_present_pin(ac_present_pin),
        .relay1(relay1), .relay2(relay2), .ac_connect(ac_connect), .irq(irq));
    gss_gen_model i_gen (.clk_sys(clk_sys), .relay1(relay1), .no_fuel(no_fuel),
        .ac_present(ac_present_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobe dropped and one edge let pass, so calls may follow directly
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, exp);
        @(posedge clk_sys);
    endtask
    // bounded wait on relay1 (0), ac_connect (1)
    task automatic wait_for(input int i, input logic v, input int lim);
        for (int k = 0; k < lim && (i ? ac_connect : relay1) !== v; k++)
            @(posedge clk_sys);
        if ((i ? ac_connect : relay1) !== v)
        begin
            n_fail++;
            $display("MISMATCH t=%0t wait ran out", $time);
            give_verdict();
        end
    endtask
    // expected input state from configuration and pin levels
    function automatic logic [31:0] in_exp(input logic [31:0] c, input logic [3:0] d);
        logic a;
        in_exp = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            a = d[i] ^ c[8*i+CFG_LOGIC_INV];
            if (c[8*i +: 4] > FN_PULSE)
            begin
                in_exp[ST_ACT_LSB+i] = a;
                in_exp[ST_LABEL_LSB+i] = a ^ c[8*i+CFG_LABEL_INV];
                in_exp[ST_ALARM_LSB+i] = a & c[8*i+CFG_ALARM_EN];
            end
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(ADR_WARM, 32'hFFFF_FFFF, WARM_RST);
        rd(ADR_COOL, 32'hFFFF_FFFF, COOL_RST);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h0);
        rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
        // every function code on input 0, fixed mixes of inversions on the others
        for (int f = 0; f < 10; f++)
        begin
            for (int lv = 0; lv < 2; lv++)
            begin
                cfg = {8'h72, 8'h54, 8'h36, 4'h1, f[3:0]};
                din_pin <= (lv == 1) ? 4'b0101 : 4'b1010;
                wr(ADR_IN_CFG, cfg);
                repeat (5) @(posedge clk_sys);
                rd(ADR_IN_STATE, 32'hFFFF_FFFF, in_exp(cfg, din_pin));
            end
        end
        #1 check({31'h0, irq}, 32'h0);
        wr(ADR_IRQ_MASK, 32'h1);
        #1 check({31'h0, irq}, 32'h1);
        wr(ADR_IRQ_STAT, 32'h1);
        #1 check({31'h0, irq}, 32'h0);
        wr(ADR_IRQ_MASK, 32'h0);
        // manual run with generator detection, then fuel loss
        wr(ADR_WARM, 32'h2);
        wr(ADR_COOL, 32'h2);
        wr(ADR_SVC_INT, 32'h2);
        wr(ADR_CTRL, 32'h20);
        rd(ADR_SVC_LEFT, 32'hFFFF_FFFF, 32'h2);
        wr(ADR_CTRL, 32'h06);
        #1 check({30'h0, relay2, relay1}, 32'h1);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h1);
        wait_for(1, 1'b1, 100);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h2);
        no_fuel <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADR_IRQ_STAT, 32'hA, 32'hA);
        no_fuel <= 1'b0;
        wr(ADR_CTRL, 32'h04);
        #1 check({30'h0, relay1, ac_connect}, 32'h2);
        wait_for(0, 1'b0, 200);
        repeat ((STOP_HOLD_S + 2) * SEC) @(posedge clk_sys);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h0);
        wr(ADR_TOTAL, 32'h1234);
        rd(ADR_TOTAL, 32'hFFFF_FFFF, 32'h1234);
        // automatic run: condition alone refused, minimum run holds the stop
        wr(ADR_MIN_RUN, 32'h5);
        wr(ADR_CTRL, 32'h10);
        repeat (20) @(posedge clk_sys);
        check({31'h0, relay1}, 32'h0);
        wr(ADR_CTRL, 32'h11);
        wait_for(1, 1'b1, 100);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h3);
        wr(ADR_CTRL, 32'h01);
        rd(ADR_GEN_STATE, 32'hFFFF_FFFF, 32'h3);
        wait_for(0, 1'b0, 300);
        // auto left off: alarm only past ten minutes
        wr(ADR_CTRL, 32'h08);
        wr(ADR_IRQ_STAT, 32'hF);
        repeat ((NOAUTO_LIMIT_S - 20) * SEC) @(posedge clk_sys);
        rd(ADR_IRQ_STAT, 32'h4, 32'h0);
        repeat (30 * SEC) @(posedge clk_sys);
        rd(ADR_IRQ_STAT, 32'h4, 32'h4);
        give_verdict();
    end
endmodule

bind gss_core gss_core_props #(.N_IN(N_IN), .SEC_CYC(SEC_CYC), .DAY_SEC(DAY_SEC)) i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din_pin(din_pin),
    .ac_present_pin(ac_present_pin), .relay1(relay1), .relay2(relay2),
    .ac_connect(ac_connect), .irq(irq));
